/* hdl/tps_regs.vh */
// constants for the test pattern sequencer
`ifndef TPS_REGS_VH
`define TPS_REGS_VH
`define TPS_MODE_ZSUB      2'h0
`define TPS_MODE_DATA      2'h1
`define TPS_MODE_MIXED     2'h2
`define TPS_ADDR_W         12
`define TPS_MEM_DEPTH      4096
`define TPS_LEN_W          29
`define TPS_LEN_MIN        29'h0000002
`define TPS_LEN_MAX        29'h10000000
`define TPS_ROWS_MIN       5'h01
`define TPS_ROWS_MAX       5'h10
`define TPS_BLOCKS_MAX     9'h1FF
`define TPS_PRBS_N7        2'h0
`define TPS_PRBS_N23       2'h1
`define TPS_PRBS_N31       2'h2
`define TPS_LFSR_SEED      31'h7FFFFFFF
`define TPS_SCR_SEED       7'h7F
`define TPS_FIFO_W         1
`define TPS_FIFO_DEPTH     16
`define TPS_FIFO_AW        4
`endif

/* hdl/tps_sequencer.v */
// test pattern sequencer with output fifo
// Summary of operation
// - zero-substitution power-of-two length forces final period bit to chosen last-bit value
// - positive polarity maps one to high; inverted polarity maps zero to high
// - confirmed edit content is written into pattern memory before generation
// - loading indicator stays high during the whole memory transfer
// - mixed rows are segment then prbs; rows form blocks; blocks play in order
// - up to 511 blocks in a mixed pattern
// - row prbs is maximal length with 7, 23 or 31 stages
// - seven-stage scrambler touches only the selected target areas
// - scramble toggle starts and stops scrambling; status shows the state
// - first-row data area of any block is never scrambled; such selection rejected
// - restart mode reseeds prbs at every new block
// - overwrite cut copies range to clipboard then clears it to zero
// - insert cut removes range, shifts later bits down, pads zeros at end
// - rows per block configurable from one to sixteen
// - data length configurable from two bits up to the maximum
`timescale 1ns/10ps
`include "tps_regs.vh"

////////////////////////////////////////////////////////////////////////
module tps_fifo #(
	parameter W  = 1,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clk,
	input  wire          rst,
	input  wire [W-1:0]  in_data,
	input  wire          in_valid,
	output wire          in_ready,
	output wire [W-1:0]  out_data,
	output wire          out_valid,
	input  wire          out_ready
);
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW:0]   wp_r;
	reg  [AW:0]   rp_r;
	wire          full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire          empty = (wp_r == rp_r);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_r[AW-1:0]];
	always @(posedge clk) begin
		if (in_valid && !full)
			mem[wp_r[AW-1:0]] <= in_data;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= {(AW+1){1'b0}};
			rp_r <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wp_r <= wp_r + 1'b1;
			if (out_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule // tps_fifo

////////////////////////////////////////////////////////////////////////
module tps_sequencer (
	// clock and reset
	input  wire                    I_CLOCK,
	input  wire                    I_RST,
	// pattern settings
	input  wire [1:0]              I_MODE,
	input  wire                    I_RUN,
	input  wire                    I_INVERTED_POLARITY,
	input  wire                    I_LAST_BIT_ONE,
	input  wire                    I_POW2_LEN,
	input  wire [`TPS_LEN_W-1:0]   I_DATA_LEN,
	input  wire [1:0]              I_PRBS_STAGES,
	input  wire [8:0]              I_NUM_BLOCKS,
	input  wire [4:0]              I_NUM_ROWS,
	input  wire [15:0]             I_ROW_PRBS_LEN,
	input  wire                    I_CONSECUTIVE,
	// scramble control
	input  wire                    I_SCR_TOGGLE,
	input  wire                    I_SCR_TGT_FIRST_DATA,
	input  wire                    I_SCR_TGT_DATA,
	input  wire                    I_SCR_TGT_PRBS,
	// editor load port
	input  wire                    I_LOAD_START,
	input  wire                    I_LOAD_WE,
	input  wire [`TPS_ADDR_W-1:0]  I_LOAD_ADDR,
	input  wire                    I_LOAD_BIT,
	input  wire                    I_LOAD_DONE,
	// edit commands
	input  wire                    I_CUT,
	input  wire                    I_CUT_INSERT,
	input  wire [`TPS_ADDR_W-1:0]  I_CUT_START,
	input  wire [`TPS_ADDR_W-1:0]  I_CUT_END,
	// status
	output reg                     O_LOADING,
	output reg                     O_EDIT_BUSY,
	output reg                     O_SCR_ON,
	output reg                     O_SCR_REJECT,
	output reg                     O_CFG_ERR,
	output reg                     O_CLIP_BIT,
	output reg                     O_CLIP_VALID,
	// serial output
	output reg                     O_DATA,
	output reg                     O_DATA_VALID,
	input  wire                    I_DATA_READY
);
	localparam ST_IDLE = 3'h1;
	localparam ST_CUT  = 3'h2;
	localparam ST_PAD  = 3'h4;

	function [30:0] lfsr_step;
		input [30:0] s;
		input [1:0]  n;
		begin
			case (n)
				`TPS_PRBS_N23: lfsr_step = {8'h00, s[21:0], s[22] ^ s[17]};
				`TPS_PRBS_N31: lfsr_step = {s[29:0], s[30] ^ s[27]};
				default:       lfsr_step = {24'h000000, s[5:0], s[6] ^ s[5]};
			endcase
		end
	endfunction

	function lfsr_out;
		input [30:0] s;
		input [1:0]  n;
		begin
			case (n)
				`TPS_PRBS_N23: lfsr_out = s[22];
				`TPS_PRBS_N31: lfsr_out = s[30];
				default:       lfsr_out = s[6];
			endcase
		end
	endfunction

	reg                     mem [0:`TPS_MEM_DEPTH-1];
	reg  [2:0]              st_r;
	reg  [`TPS_ADDR_W-1:0]  ep_r;
	reg  [`TPS_ADDR_W-1:0]  pad_r;
	reg  [`TPS_LEN_W-1:0]   pos_r;
	reg  [8:0]              blk_r;
	reg  [4:0]              row_r;
	reg                     in_prbs_r;
	reg  [15:0]             pcnt_r;
	reg  [30:0]             lfsr_r;
	reg  [6:0]              scr_r;
	reg                     scr_tgl_d_r;

	wire [`TPS_ADDR_W-1:0]  cut_len  = I_CUT_END - I_CUT_START + 1'b1;
	wire [`TPS_ADDR_W-1:0]  data_end = I_DATA_LEN[`TPS_ADDR_W-1:0] - 1'b1;
	wire                    cfg_ok   = (I_DATA_LEN >= `TPS_LEN_MIN) && (I_DATA_LEN <= `TPS_LEN_MAX) &&
	                                   (I_NUM_ROWS >= `TPS_ROWS_MIN) && (I_NUM_ROWS <= `TPS_ROWS_MAX) &&
	                                   (I_NUM_BLOCKS != 9'h000);
	wire                    gen_ok   = I_RUN && !O_LOADING && (st_r == ST_IDLE) && cfg_ok;
	wire                    f_ready;
	wire                    f_data;
	wire                    f_valid;
	wire                    step     = gen_ok && f_ready;
	wire                    mixed    = (I_MODE == `TPS_MODE_MIXED);
	wire                    seg_end  = (pos_r == I_DATA_LEN - 1'b1);
	wire                    prbs_end = (pcnt_r == I_ROW_PRBS_LEN - 1'b1);
	wire                    row_end  = mixed ? (in_prbs_r && prbs_end) : seg_end;
	wire                    blk_end  = row_end && (row_r == I_NUM_ROWS - 1'b1);
	wire                    mem_bit  = mem[pos_r[`TPS_ADDR_W-1:0]];
	wire                    prbs_bit = lfsr_out(lfsr_r, I_PRBS_STAGES);
	wire                    first_dt = !in_prbs_r && (row_r == 5'h00);
	wire                    tgt      = in_prbs_r ? I_SCR_TGT_PRBS : (!first_dt && I_SCR_TGT_DATA);
	wire                    raw_bit  = (mixed && in_prbs_r) ? prbs_bit : mem_bit;
	wire                    zs_bit   = (I_MODE == `TPS_MODE_ZSUB && I_POW2_LEN && seg_end) ? I_LAST_BIT_ONE : raw_bit;
	wire                    scr_bit  = (O_SCR_ON && mixed && tgt) ? (zs_bit ^ scr_r[6]) : zs_bit;
	wire                    pol_bit  = scr_bit ^ I_INVERTED_POLARITY;

	////////////////////////////////////////////////////////////////////////
	// memory load and edit
	always @(posedge I_CLOCK) begin
		if (I_LOAD_WE && O_LOADING && st_r == ST_IDLE)
			mem[I_LOAD_ADDR] <= I_LOAD_BIT;
		else if (st_r == ST_CUT && !I_CUT_INSERT)
			mem[ep_r] <= 1'b0;
		else if (st_r == ST_CUT)
			mem[ep_r] <= mem[ep_r + cut_len];
		else if (st_r == ST_PAD)
			mem[pad_r] <= 1'b0;
	end

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			st_r         <= ST_IDLE;
			ep_r         <= {`TPS_ADDR_W{1'b0}};
			pad_r        <= {`TPS_ADDR_W{1'b0}};
			O_LOADING    <= 1'b0;
			O_EDIT_BUSY  <= 1'b0;
			O_CLIP_BIT   <= 1'b0;
			O_CLIP_VALID <= 1'b0;
		end else begin
			O_CLIP_VALID <= 1'b0;
			if (I_LOAD_START)
				O_LOADING <= 1'b1;
			else if (I_LOAD_DONE)
				O_LOADING <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					if (I_CUT && !O_LOADING) begin
						st_r        <= ST_CUT;
						ep_r        <= I_CUT_START;
						O_EDIT_BUSY <= 1'b1;
					end
				end
				ST_CUT: begin
					O_CLIP_BIT   <= mem[ep_r + (I_CUT_INSERT ? {`TPS_ADDR_W{1'b0}} : {`TPS_ADDR_W{1'b0}})];
					O_CLIP_VALID <= (ep_r <= I_CUT_END);
					if (!I_CUT_INSERT && ep_r == I_CUT_END) begin
						st_r        <= ST_IDLE;
						O_EDIT_BUSY <= 1'b0;
					end else if (I_CUT_INSERT && ep_r + cut_len == data_end) begin
						st_r  <= ST_PAD;
						pad_r <= data_end - cut_len + 1'b1;
					end else begin
						ep_r <= ep_r + 1'b1;
					end
				end
				ST_PAD: begin
					if (pad_r == data_end) begin
						st_r        <= ST_IDLE;
						O_EDIT_BUSY <= 1'b0;
					end else begin
						pad_r <= pad_r + 1'b1;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scramble control
	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_SCR_ON     <= 1'b0;
			O_SCR_REJECT <= 1'b0;
			O_CFG_ERR    <= 1'b0;
			scr_tgl_d_r  <= 1'b0;
		end else begin
			scr_tgl_d_r  <= I_SCR_TOGGLE;
			O_SCR_REJECT <= I_SCR_TGT_FIRST_DATA;
			O_CFG_ERR    <= !cfg_ok;
			if (I_SCR_TOGGLE && !scr_tgl_d_r)
				O_SCR_ON <= !O_SCR_ON;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pattern generation
	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			pos_r     <= {`TPS_LEN_W{1'b0}};
			blk_r     <= 9'h000;
			row_r     <= 5'h00;
			in_prbs_r <= 1'b0;
			pcnt_r    <= 16'h0000;
			lfsr_r    <= `TPS_LFSR_SEED;
			scr_r     <= `TPS_SCR_SEED;
		end else if (!gen_ok) begin
			pos_r     <= {`TPS_LEN_W{1'b0}};
			blk_r     <= 9'h000;
			row_r     <= 5'h00;
			in_prbs_r <= 1'b0;
			pcnt_r    <= 16'h0000;
			lfsr_r    <= `TPS_LFSR_SEED;
			scr_r     <= `TPS_SCR_SEED;
		end else if (step) begin
			scr_r <= {scr_r[5:0], scr_r[6] ^ scr_r[5]};
			if (mixed && in_prbs_r)
				lfsr_r <= lfsr_step(lfsr_r, I_PRBS_STAGES);
			if (!mixed) begin
				pos_r <= seg_end ? {`TPS_LEN_W{1'b0}} : pos_r + 1'b1;
			end else if (!in_prbs_r) begin
				pcnt_r <= 16'h0000;
				if (seg_end) begin
					in_prbs_r <= 1'b1;
					pos_r     <= {`TPS_LEN_W{1'b0}};
				end else begin
					pos_r <= pos_r + 1'b1;
				end
			end else if (prbs_end) begin
				in_prbs_r <= 1'b0;
				if (blk_end) begin
					row_r <= 5'h00;
					blk_r <= (blk_r == I_NUM_BLOCKS - 1'b1) ? 9'h000 : blk_r + 1'b1;
					if (!I_CONSECUTIVE)
						lfsr_r <= `TPS_LFSR_SEED;
					// consecutive mode lets the lfsr run on
				end else begin
					row_r <= row_r + 1'b1;
				end
			end else begin
				pcnt_r <= pcnt_r + 1'b1;
			end
		end
	end

	tps_fifo #(
		.W  (`TPS_FIFO_W),
		.D  (`TPS_FIFO_DEPTH),
		.AW (`TPS_FIFO_AW)
	) u_fifo (
		.clk       (I_CLOCK),
		.rst       (I_RST),
		.in_data   (pol_bit),
		.in_valid  (gen_ok),
		.in_ready  (f_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (I_DATA_READY && (!O_DATA_VALID || I_DATA_READY))
	);

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_DATA       <= 1'b0;
			O_DATA_VALID <= 1'b0;
		end else if (I_DATA_READY || !O_DATA_VALID) begin
			O_DATA       <= f_data;
			O_DATA_VALID <= f_valid && I_DATA_READY;
		end
	end
endmodule // tps_sequencer

/* tb/tps_sequencer_properties.sv */
// concurrent checks on the test pattern sequencer ports
`timescale 1ns/10ps
`include "tps_regs.vh"
module tps_props (
	// clock, reset and stimulus
	input wire logic                   I_CLOCK, I_RST, I_LOAD_START, I_LOAD_DONE, I_CUT, I_DATA_READY,
	input wire logic                   I_SCR_TOGGLE, I_SCR_TGT_FIRST_DATA,
	input wire logic [1:0]             I_MODE,
	input wire logic [4:0]             I_NUM_ROWS,
	input wire logic [`TPS_LEN_W-1:0]  I_DATA_LEN,
	// observed outputs
	input wire logic                   O_LOADING, O_EDIT_BUSY, O_SCR_ON, O_SCR_REJECT, O_CFG_ERR, O_DATA, O_DATA_VALID
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	a_load_start: assert property (I_LOAD_START |=> O_LOADING)
		else $error("loading not raised");
	a_load_hold: assert property (O_LOADING && !I_LOAD_DONE |=> O_LOADING)
		else $error("loading dropped early");
	a_load_done: assert property (I_LOAD_DONE && !I_LOAD_START |=> !O_LOADING)
		else $error("loading not cleared");
	a_data_hold: assert property (O_DATA_VALID && !I_DATA_READY |=> O_DATA_VALID && $stable(O_DATA))
		else $error("output changed while stalled");
	a_cut_start: assert property (I_CUT && !O_LOADING && !O_EDIT_BUSY |=> O_EDIT_BUSY)
		else $error("cut not started");
	a_cut_refuse: assert property (I_CUT && O_LOADING && !O_EDIT_BUSY |=> !O_EDIT_BUSY)
		else $error("cut accepted while loading");
	a_scr_flip: assert property ($rose(I_SCR_TOGGLE) |-> ##2 O_SCR_ON != $past(O_SCR_ON, 2))
		else $error("scramble state not flipped");
	a_scr_cause: assert property ($changed(O_SCR_ON) |-> $past(I_SCR_TOGGLE) || $past(I_SCR_TOGGLE, 2))
		else $error("scramble state changed alone");
	a_first_reject: assert property (1'b1 |=> O_SCR_REJECT == $past(I_SCR_TGT_FIRST_DATA))
		else $error("first row target not rejected");
	a_rows_range: assert property ((I_MODE == `TPS_MODE_MIXED && (I_NUM_ROWS == 5'h00 ||
		I_NUM_ROWS > `TPS_ROWS_MAX)) [*2] |-> O_CFG_ERR)
		else $error("bad row count accepted");
	a_len_range: assert property ((I_MODE == `TPS_MODE_DATA && I_DATA_LEN < `TPS_LEN_MIN) [*2] |-> O_CFG_ERR)
		else $error("bad length accepted");
endmodule // tps_props
bind tps_sequencer tps_props p_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_LOAD_START(I_LOAD_START),
	.I_LOAD_DONE(I_LOAD_DONE), .I_CUT(I_CUT), .I_DATA_READY(I_DATA_READY), .I_SCR_TOGGLE(I_SCR_TOGGLE),
	.I_SCR_TGT_FIRST_DATA(I_SCR_TGT_FIRST_DATA), .I_MODE(I_MODE), .I_NUM_ROWS(I_NUM_ROWS),
	.I_DATA_LEN(I_DATA_LEN), .O_LOADING(O_LOADING), .O_EDIT_BUSY(O_EDIT_BUSY), .O_SCR_ON(O_SCR_ON),
	.O_SCR_REJECT(O_SCR_REJECT), .O_CFG_ERR(O_CFG_ERR), .O_DATA(O_DATA), .O_DATA_VALID(O_DATA_VALID));

/* tb/tps_sink.sv */
// serial consumer model that can stall
`timescale 1ns/10ps
module tps_sink (
	input wire logic clk,
	input wire logic slow,
	input wire logic valid,
	input wire logic data,
	output logic     ready
);
	logic       bits [$];
	logic [1:0] cnt = 2'h0;
	initial ready = 1'b0;
	always @(posedge clk) begin
		if (valid && ready) bits.push_back(data);
		cnt   <= cnt + 2'h1;
		ready <= !(slow && cnt == 2'h0);
	end
endmodule // tps_sink

/* tb/testbench.sv */
// self-checking bench for the test pattern sequencer
`timescale 1ns/10ps
`include "tps_regs.vh"
module testbench;
	logic clk = 0, rst = 1, run = 0, inv = 0, cons = 0, tog = 0, tfd = 0, tdt = 0, slow = 0;
	logic ls = 0, lwe = 0, lbit = 0, ld = 0, cut = 0, cins = 0, lb = 0, p2 = 0, tpr = 0;
	logic [1:0] mode = 0;
	logic [1:0] pst = `TPS_PRBS_N7;
	logic [`TPS_LEN_W-1:0] dlen = 8;
	logic [8:0] nblk = 1;
	logic [4:0] nrow = 1;
	logic [15:0] plen = 10;
	logic [11:0] ladr = 0, cs = 0, ce = 0;
	wire ldo, eb, son, srj, cerr, cb, cv, dat, dv, rdy;
	int mismatches = 0, n_tests = 0;
	logic got [$];
	tps_sequencer dut_u (.I_CLOCK(clk), .I_RST(rst), .I_MODE(mode), .I_RUN(run), .I_INVERTED_POLARITY(inv),
		.I_LAST_BIT_ONE(lb), .I_POW2_LEN(p2), .I_DATA_LEN(dlen), .I_PRBS_STAGES(pst),
		.I_NUM_BLOCKS(nblk), .I_NUM_ROWS(nrow), .I_ROW_PRBS_LEN(plen), .I_CONSECUTIVE(cons),
		.I_SCR_TOGGLE(tog), .I_SCR_TGT_FIRST_DATA(tfd), .I_SCR_TGT_DATA(tdt), .I_SCR_TGT_PRBS(tpr),
		.I_LOAD_START(ls), .I_LOAD_WE(lwe), .I_LOAD_ADDR(ladr), .I_LOAD_BIT(lbit), .I_LOAD_DONE(ld),
		.I_CUT(cut), .I_CUT_INSERT(cins), .I_CUT_START(cs), .I_CUT_END(ce),
		.O_LOADING(ldo), .O_EDIT_BUSY(eb), .O_SCR_ON(son), .O_SCR_REJECT(srj), .O_CFG_ERR(cerr),
		.O_CLIP_BIT(cb), .O_CLIP_VALID(cv), .O_DATA(dat), .O_DATA_VALID(dv), .I_DATA_READY(rdy));
	tps_sink sink_u (.clk(clk), .slow(slow), .valid(dv), .data(dat), .ready(rdy));
	initial forever #12.5 clk = ~clk;
	initial begin repeat (60000) @(posedge clk); mismatches++; stop_test; end
	////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin mismatches++; $display("MISMATCH %0t %s", $time, m); end
	endtask
	task cyc(input int n); repeat (n) @(posedge clk); #1; endtask
	task reset_dut; rst = 1; cyc(10); rst = 0; endtask
	task load(input logic [7:0] p);
		ls = 1; cyc(1); ls = 0;
		for (int i = 0; i < 8; i++) begin
			lwe = 1; ladr = 12'(i); lbit = p[i]; cut = (i == 0); cyc(1);
			chk(ldo === 1'b1, "loading low");
		end
		lwe = 0; cut = 0; ld = 1; cyc(1); ld = 0; cyc(1);
		chk(ldo === 1'b0 && eb === 1'b0, "loading stuck or cut taken");
	endtask
	task stream(input int n);
		sink_u.bits.delete(); run = 1;
		for (int k = 0; k < 3000 && sink_u.bits.size() < n; k++) cyc(1);
		run = 0;
		chk(sink_u.bits.size() >= n, "no output");
	endtask
	task t_data(input logic iv, input int len, input logic [7:0] p);
		reset_dut; mode = `TPS_MODE_DATA; dlen = 29'(len); inv = iv; slow = iv; load(p); stream(16);
		for (int i = 0; i < 16; i++) chk(sink_u.bits[i] === (p[i % len] ^ iv), "data bit");
		inv = 0; slow = 0; dlen = 8;
	endtask
	task t_cut(input logic ins, input logic [7:0] e);
		reset_dut; mode = `TPS_MODE_DATA; load(8'hB4);
		cins = ins; cs = 2; ce = 4; cut = 1; cyc(1); cut = 0;
		chk(eb === 1'b1, "cut not busy");
		got.delete();
		for (int n = 0; n < 200 && (eb === 1'b1 || cv === 1'b1); n++) begin if (cv) got.push_back(cb); cyc(1); end
		chk(got.size() == 3 && got[0] === 1'b1 && got[1] === 1'b0 && got[2] === 1'b1, "clip");
		stream(8);
		for (int i = 0; i < 8; i++) chk(sink_u.bits[i] === e[i], "cut result");
	endtask
	task t_scr;
		reset_dut; mode = `TPS_MODE_MIXED; tdt = 1;
		for (int j = 0; j < 2; j++) begin
			tog = 1; cyc(1); tog = 0; cyc(3);
			chk(son === (j == 0), "scramble state");
		end
		tfd = 1; cyc(2); chk(srj === 1'b1, "no reject");
		tfd = 0; cyc(2); chk(srj === 1'b0, "reject stuck");
		tdt = 0;
	endtask
	// mixed rows of two data bits and two prbs bits, first-row target always requested
	task t_scram(input logic pr, input logic [15:0] e);
		reset_dut; mode = `TPS_MODE_MIXED; dlen = 2; nrow = 2; plen = 2; tdt = 1; tfd = 1; tpr = pr;
		tog = 1; cyc(1); tog = 0; load(8'h03); stream(16);
		for (int i = 0; i < 16; i++) chk(sink_u.bits[i] === e[i], "scrambled bit");
		dlen = 8; nrow = 1; plen = 10; tdt = 0; tfd = 0; tpr = 0;
	endtask
	task t_zsub(input logic b, input logic [7:0] p);
		reset_dut; mode = `TPS_MODE_ZSUB; p2 = 1; lb = b; load(p); stream(16);
		for (int i = 0; i < 16; i++) chk(sink_u.bits[i] === ((i % 8 == 7) ? b : p[i % 8]), "last bit");
		p2 = 0; lb = 0;
	endtask
	task t_stage;
		reset_dut; mode = `TPS_MODE_MIXED; dlen = 2; plen = 30; pst = `TPS_PRBS_N23; load(8'h00); stream(32);
		for (int i = 0; i < 30; i++) chk(sink_u.bits[i + 2] === (i < 23), "prbs23 bit");
		pst = `TPS_PRBS_N7; plen = 10; dlen = 8;
	endtask
	task t_cfg;
		logic [4:0] rw [4];
		logic [`TPS_LEN_W-1:0] ln [4];
		rw = '{5'h00, 5'h01, 5'h10, 5'h11};
		ln = '{29'h1, `TPS_LEN_MIN, `TPS_LEN_MAX, `TPS_LEN_MAX + 29'h1};
		reset_dut; mode = `TPS_MODE_MIXED; nblk = `TPS_BLOCKS_MAX;
		for (int i = 0; i < 4; i++) begin nrow = rw[i]; cyc(3); chk(cerr === (i == 0 || i == 3), "rows"); end
		nrow = 1; nblk = 9'h000; cyc(3); chk(cerr === 1'b1, "blocks");
		nrow = 1; nblk = 1; mode = `TPS_MODE_DATA;
		for (int i = 0; i < 4; i++) begin dlen = ln[i]; cyc(3); chk(cerr === (i == 0 || i == 3), "len"); end
		dlen = 8;
	endtask
	task t_mixed(input logic c);
		logic same;
		logic [19:0] pr;
		pr = 20'h8207F;
		reset_dut; mode = `TPS_MODE_MIXED; dlen = 2; cons = c; load(8'h02); stream(24);
		chk(sink_u.bits[0] === 1'b0 && sink_u.bits[1] === 1'b1 && sink_u.bits[12] === 1'b0 &&
			sink_u.bits[13] === 1'b1, "segment");
		same = 1;
		for (int i = 2; i < 12; i++) if (sink_u.bits[i] !== sink_u.bits[i + 12]) same = 0;
		chk(same === !c, "prbs continuity");
		for (int i = 0; i < 10; i++)
			chk(sink_u.bits[i + 2] === pr[i] && sink_u.bits[i + 14] === pr[c ? i + 10 : i], "prbs bit");
		cons = 0; dlen = 8;
	endtask
	initial begin
		reset_dut; t_cfg; t_scr;
		t_scram(0, 16'hDFCF); t_scram(1, 16'hDF83);
		t_data(0, 8, 8'hB4); t_data(1, 2, 8'h01);
		t_cut(0, 8'hA0); t_cut(1, 8'h14);
		t_mixed(0); t_mixed(1);
		t_zsub(1, 8'h00); t_zsub(0, 8'hFF); t_stage;
		stop_test;
	end
endmodule // testbench
